// ### src/apdc_power_ctrl.sv
// Automatic power-down unit with mode registers and signal gating
`timescale 1ns/100ps
`default_nettype none
`include "apdc_map.svh"
module apdc_power_ctrl
  import apdc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic powerOnRst,
  input wire logic auxLogicClockIn,
  input wire logic addrLatchStrobe,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic programStoreStrobe,
  input wire logic chipSelectN,
  input wire logic [ADDR_W-1:0] mcuAddrData,
  input wire logic modeZeroWe,
  input wire logic modeTwoWe,
  input wire logic [7:0] modeWrData,
  output logic [7:0] powerModeRegZero,
  output logic [7:0] powerModeRegTwo,
  output logic powerDownFlag,
  output logic [3:0] idleCount,
  output logic [ADDR_W-1:0] memAddrData,
  output logic memSelect,
  output logic lowPowerMode,
  output logic arrayClk,
  output logic mcellClk,
  output logic arrayWrStrobe,
  output logic arrayRdStrobe,
  output logic arrayPsStrobe,
  output logic arrayAleStrobe,
  output logic holdPins,
  output logic periphOe
);
  // How the block behaves, in brief
  //
  // Idle detection
  // - The address strobe is sampled on every system clock.
  // - Any change of the sampled strobe counts as activity.
  // - Activity clears the idle counter at once.
  // - The aux clock pin is sampled as a plain level.
  // - A sampled 0 to 1 step of that pin is one idle period.
  // - Each idle period advances the counter by one.
  // - The counter saturates at its limit, never wraps.
  // - Wrap-around would fake a fresh idle run, hence saturation.
  //
  // Entry into power-down
  // - Only when the unit enable bit is set.
  // - Only when the strobe showed no change this cycle.
  // - Only on the idle period that completes the limit.
  // - Not while chip select is held low, which would wake it.
  // - Entering under chip select low would only oscillate.
  //
  // Leaving power-down
  // - Any strobe change wakes the block in one cycle.
  // - Chip select low wakes the block in one cycle.
  // - Reset wakes the block asynchronously.
  // - Clearing the unit enable bit also wakes it.
  // - The counter restarts from zero on every wake.
  //
  // Memory side
  // - The bus copy freezes while powered down.
  // - A frozen bus keeps memories in standby under bus noise.
  // - The memory select drops while powered down.
  // - Outside power-down the select follows chip select.
  // - Select lags chip select by one cycle, a registered copy.
  //
  // Logic array side
  // - Aux clock copies are gated by register zero bits.
  // - Strobe copies are gated by register two bits.
  // - Gating is independent of power-down on purpose.
  // - Arrays keep running in power-down, no wake-up delay.
  // - Gated copies lag their pins by one cycle.
  // - The lag is the price of registered outputs.
  //
  // Mode registers
  // - Written whole, one byte per strobe.
  // - Writes are accepted in any mode, at any time.
  // - Unused bits are stored as written; software keeps them 0.
  // - They clear only when the power-on input joins reset.
  // - A warm reset alone leaves their contents.
  //
  // Pin status
  // - Hold request is high for the whole power-down.
  // - Peripheral drivers are disabled for the same span.
  // - Both come from the registered mode, never glitch.
  //
  // Limitations
  // - Aux clock must stay at or below half the system clock.
  // - Faster aux edges would be missed by the sampler.
  // - Strobe pulses shorter than one system cycle are missed.
  // - Such short pulses would not count as activity.
  // - Inputs are assumed already synchronous to sys_clk.
  //
  // Timing summary
  // - Register write visible one cycle after its strobe.
  // - Gating follows the register one cycle later again.
  // - Power-down flag rises with the count reaching the limit.
  // - Wake takes one cycle from the sampled cause.

  // Whole block state
  typedef struct packed {
    apdc_mode_e mode;
    logic [3:0] cnt;
    logic [7:0] r0;
    logic [7:0] r2;
    logic prevAux;
    logic [ADDR_W-1:0] bus;
    logic sel;
    logic arrClk;
    logic mcClk;
    logic [3:0] strobes;
  } apdc_state_s;
  apdc_state_s st_reg;
  apdc_state_s st_next;

  logic aleChanged; // Strobe transition seen
  logic auxRise; // One aux clock period passed
  logic apdEnable; // Unit enable bit
  logic [3:0] gatedStrobes; // Strobes after blocking bits

  // Strobe activity detector
  apdc_edge_detect #(.WIDTH(1)) u_ale_edge (
    .sysClk(sys_clk),
    .rst(rst),
    .sigIn(addrLatchStrobe),
    .changed(aleChanged)
  );

  assign apdEnable = st_reg.r0[`APDC_R0_APD_EN];
  // Aux clock rising edge, taken straight from the pin
  assign auxRise = auxLogicClockIn & ~st_reg.prevAux;

  // Per-strobe blocking from register two
  assign gatedStrobes = {addrLatchStrobe & ~st_reg.r2[`APDC_R2_BLK_ALE],
                         programStoreStrobe & ~st_reg.r2[`APDC_R2_BLK_PSTORE],
                         readStrobe & ~st_reg.r2[`APDC_R2_BLK_RD],
                         writeStrobe & ~st_reg.r2[`APDC_R2_BLK_WR]};

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.prevAux = auxLogicClockIn;
    // Registers writable at any time, independent of mode
    if (modeZeroWe) begin
      st_next.r0 = modeWrData;
    end
    if (modeTwoWe) begin
      st_next.r2 = modeWrData;
    end
    // Idle counter
    if (!apdEnable || aleChanged) begin
      st_next.cnt = 4'h0;
    end else if (auxRise && st_reg.cnt != `APDC_IDLE_LIMIT) begin
      st_next.cnt = st_reg.cnt + 4'h1;
    end
    unique case (st_reg.mode)
      APDC_RUN: begin
        // Enter on fifteenth idle period
        if (apdEnable && chipSelectN && !aleChanged && auxRise && st_reg.cnt == `APDC_IDLE_LIMIT - 4'h1) begin
          st_next.mode = APDC_DOWN;
        end
      end
      APDC_DOWN: begin
        // Wake on strobe activity or chip select low
        if (aleChanged || !chipSelectN || !apdEnable) begin
          st_next.mode = APDC_RUN;
          st_next.cnt = 4'h0;
        end
      end
    endcase
    // Bus frozen and select forced low while powered down
    if (st_next.mode == APDC_DOWN) begin
      st_next.sel = 1'b0;
    end else begin
      st_next.bus = mcuAddrData; // Memories only see change when awake
      st_next.sel = ~chipSelectN;
    end
    // Logic array inputs stay live in power-down
    st_next.arrClk = auxLogicClockIn & ~st_reg.r0[`APDC_R0_BLK_ARRAY_CLK];
    st_next.mcClk = auxLogicClockIn & ~st_reg.r0[`APDC_R0_BLK_MCELL_CLK];
    st_next.strobes = gatedStrobes;
  end

  // State register; reset pulse leaves mode registers unless powerOnRst is also high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg.mode <= APDC_RUN;
      st_reg.cnt <= 4'h0;
      st_reg.prevAux <= 1'b0;
      st_reg.bus <= '0;
      st_reg.sel <= 1'b0;
      st_reg.arrClk <= 1'b0;
      st_reg.mcClk <= 1'b0;
      st_reg.strobes <= 4'h0;
      if (powerOnRst) begin
        st_reg.r0 <= `APDC_REG_RESET;
        st_reg.r2 <= `APDC_REG_RESET;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign powerModeRegZero = st_reg.r0;
  assign powerModeRegTwo = st_reg.r2;
  assign powerDownFlag = (st_reg.mode == APDC_DOWN);
  assign idleCount = st_reg.cnt;
  assign memAddrData = st_reg.bus;
  assign memSelect = st_reg.sel;
  assign lowPowerMode = st_reg.r0[`APDC_R0_LOW_PWR];
  assign arrayClk = st_reg.arrClk;
  assign mcellClk = st_reg.mcClk;
  assign {arrayAleStrobe, arrayPsStrobe, arrayRdStrobe, arrayWrStrobe} = st_reg.strobes;
  assign holdPins = (st_reg.mode == APDC_DOWN);
  assign periphOe = (st_reg.mode == APDC_RUN);
endmodule : apdc_power_ctrl
`default_nettype wire

// ### src/apdc_map.svh
// Constants for the automatic power-down control block
`ifndef APDC_MAP_SVH
`define APDC_MAP_SVH
`define APDC_IDLE_LIMIT 4'hf
`define APDC_R0_APD_EN 1
`define APDC_R0_LOW_PWR 3
`define APDC_R0_BLK_ARRAY_CLK 4
`define APDC_R0_BLK_MCELL_CLK 5
`define APDC_R2_BLK_WR 2
`define APDC_R2_BLK_RD 3
`define APDC_R2_BLK_PSTORE 4
`define APDC_R2_BLK_ALE 5
`define APDC_REG_RESET 8'h00
`endif

// ### src/apdc_pkg.sv
// Types for the automatic power-down control block
package apdc_pkg;
  typedef enum logic {APDC_RUN, APDC_DOWN} apdc_mode_e;
  typedef logic [7:0] apdc_byte_t;
endpackage : apdc_pkg

// ### src/apdc_edge_detect.sv
// Transition detector for sampled inputs
`timescale 1ns/100ps
`default_nettype none
module apdc_edge_detect #(
  parameter int WIDTH = 1
) (
  input wire logic sysClk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] sigIn,
  output logic [WIDTH-1:0] changed
);
  typedef struct packed {
    logic [WIDTH-1:0] last;
  } apdc_edge_s;
  apdc_edge_s st_reg;
  apdc_edge_s st_next;

  // Remember last sample
  always_comb begin
    st_next = st_reg;
    st_next.last = sigIn;
  end

  // Any bit differing from last sample
  assign changed = sigIn ^ st_reg.last;

  // State register
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : apdc_edge_detect
`default_nettype wire

// ### sim/apdc_mcu_model.sv
// MCU side model: address strobe and bus traffic
`timescale 1ns/100ps
`default_nettype none
module apdc_mcu_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic aleRun,
  output logic addrLatchStrobe,
  output logic [15:0] mcuAddrData
);
  // Strobe toggles while running; bus keeps moving, as other bus devices would
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addrLatchStrobe <= 1'b0;
      mcuAddrData <= 16'h0000;
    end else begin
      addrLatchStrobe <= aleRun ? ~addrLatchStrobe : addrLatchStrobe;
      mcuAddrData <= mcuAddrData + 16'h0001;
    end
  end
endmodule : apdc_mcu_model
`default_nettype wire

// ### sim/apdc_power_ctrl_sva.sv
// Port checker for the power-down control block
`timescale 1ns/100ps
`default_nettype none
module apdc_power_ctrl_sva #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic addrLatchStrobe,
  input wire logic chipSelectN,
  input wire logic [7:0] powerModeRegZero,
  input wire logic [7:0] powerModeRegTwo,
  input wire logic powerDownFlag,
  input wire logic [3:0] idleCount,
  input wire logic [ADDR_W-1:0] memAddrData,
  input wire logic memSelect,
  input wire logic lowPowerMode,
  input wire logic arrayClk,
  input wire logic arrayAleStrobe,
  input wire logic holdPins,
  input wire logic periphOe
);
  // One domain, so clock and reset are declared once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_flag_at_limit: assert property ($rose(powerDownFlag) |-> idleCount == 4'hf) else $error("flag early");
  chk_wake_cs: assert property (!chipSelectN |=> !powerDownFlag) else $error("no cs wake");
  chk_mem_off: assert property (powerDownFlag && $past(powerDownFlag) |-> !memSelect) else $error("mem on");
  chk_bus_frozen: assert property (powerDownFlag [*2] |-> $stable(memAddrData)) else $error("bus moved");
  chk_pins_held: assert property (holdPins |-> !periphOe) else $error("periph driven");
  chk_speed_bit: assert property (1 |-> lowPowerMode == powerModeRegZero[3]) else $error("speed bit");
  chk_clk_block: assert property (powerModeRegZero[4] [*2] |-> !arrayClk) else $error("clk leak");
  chk_ale_block: assert property (powerModeRegTwo[5] [*2] |-> !arrayAleStrobe) else $error("ale leak");
  chk_off_idle: assert property (!powerModeRegZero[1] |=> idleCount <= $past(idleCount)) else $error("counting");
  chk_ale_clear: assert property ($changed(addrLatchStrobe) |=> idleCount == 4'h0) else $error("no clear");
endmodule : apdc_power_ctrl_sva
`default_nettype wire

// ### sim/apdc_power_ctrl_tb_top.sv
// Testbench for the power-down control block
`timescale 1ns/100ps
`default_nettype none
module apdc_power_ctrl_tb_top;
  logic sys_clk = 0, rst = 1, por = 1, aux = 0, csN = 1, aleRun = 1, we0 = 0, we2 = 0;
  logic [7:0] wd = 8'h00, r0, r2;
  logic ale, pdf, ms, lp, ac, mc, aw, ar, ap, aa, hp, po;
  logic [3:0] ic;
  logic [15:0] ad, md;
  int err_total = 0, check_count = 0;
  apdc_mcu_model mcu (.sys_clk(sys_clk), .rst(rst), .aleRun(aleRun), .addrLatchStrobe(ale), .mcuAddrData(ad));
  // Unused control strobes tied idle
  apdc_power_ctrl uut (.sys_clk(sys_clk), .rst(rst), .powerOnRst(por), .auxLogicClockIn(aux),
    .addrLatchStrobe(ale), .writeStrobe(1'b0), .readStrobe(1'b0), .programStoreStrobe(1'b0),
    .chipSelectN(csN), .mcuAddrData(ad), .modeZeroWe(we0), .modeTwoWe(we2), .modeWrData(wd),
    .powerModeRegZero(r0), .powerModeRegTwo(r2), .powerDownFlag(pdf), .idleCount(ic), .memAddrData(md),
    .memSelect(ms), .lowPowerMode(lp), .arrayClk(ac), .mcellClk(mc), .arrayWrStrobe(aw),
    .arrayRdStrobe(ar), .arrayPsStrobe(ap), .arrayAleStrobe(aa), .holdPins(hp), .periphOe(po));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    @(negedge sys_clk);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Register write, one cycle strobe, effects settled after
  task automatic wr(input logic two, input logic [7:0] d);
    @(posedge sys_clk) {we2, we0, wd} <= {two, ~two, d};
    @(posedge sys_clk) {we2, we0} <= 2'b00;
    repeat (3) @(posedge sys_clk);
  endtask : wr
  // Aux clock periods, two system cycles each
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk) aux <= 1'b1;
      @(posedge sys_clk) aux <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask : pulses
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    {rst, por} <= 2'b00;
    @(negedge sys_clk) chk("r0", r0, 8'h00);
    wr(1'b0, 8'h3a);
    chk("lowpwr", lp, 1'b1);
    wr(1'b1, 8'h20);
    pulses(3);
    chk("arrclk", ac, 1'b0);
    chk("alegate", aa, 1'b0);
    chk("mcclk", mc, 1'b0);
    @(posedge sys_clk) aleRun <= 1'b0;
    pulses(14);
    chk("early", pdf, 1'b0);
    pulses(1);
    chk("flag", pdf, 1'b1);
    chk("count", ic, 4'hf);
    chk("memsel", ms, 1'b0);
    chk("hold", {hp, po}, 2'b10);
    @(posedge sys_clk) aleRun <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("alewake", {pdf, ic}, 5'h00);
    @(posedge sys_clk) aleRun <= 1'b0;
    pulses(15);
    @(posedge sys_clk) csN <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("cswake", {pdf, ms}, 2'b01);
    @(posedge sys_clk) {csN, rst} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk) chk("warm", r0, 8'h3a);
    wr(1'b0, 8'h00);
    pulses(20);
    chk("off", {pdf, ic}, 5'h00);
    results();
  end
endmodule : apdc_power_ctrl_tb_top
bind apdc_power_ctrl apdc_power_ctrl_sva #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire
